// >>> rtl/bsi_defs.svh
`ifndef BSI_DEFS_SVH
`define BSI_DEFS_SVH

// host i/o port addresses
`define BSI_ADDR_JUMPER 16'h00E0
`define BSI_ADDR_IDENT 16'h00E1

// jumper status fields
`define BSI_FW_SEL_BIT 5
`define BSI_GEN_IN_BIT 0

// identification fields
`define BSI_PROD_MSB 7
`define BSI_PROD_LSB 3
`define BSI_REV_MSB 2
`define BSI_REV_LSB 1
`define BSI_EXT_TEMP_BIT 0

// identification values; the product code is arbitrary
`define BSI_PRODUCT_CODE 5'h05
`define BSI_REV_CURRENT 2'h0

// read data before the first read
`define BSI_RDATA_RESET 8'h00

// interrupt sources and lines
`define BSI_NUM_SRC 15
`define BSI_NUM_LINES 16
`define BSI_CASCADE_LINE 2

// default line of each source
`define BSI_IRQ_TIMER0 4'h0
`define BSI_IRQ_KEYBOARD 4'h1
`define BSI_IRQ_COM2 4'h3
`define BSI_IRQ_COM1 4'h4
`define BSI_IRQ_FLOPPY 4'h6
`define BSI_IRQ_RTC 4'h8
`define BSI_IRQ_PCI 4'hB
`define BSI_IRQ_MOUSE 4'hC
`define BSI_IRQ_FPU 4'hD
`define BSI_IRQ_DISK 4'hE
`define BSI_IRQ_NONE 4'h0

// lines a routing group may use
`define BSI_GRPA_ALLOWED 16'h8EB8
`define BSI_GRPB_ALLOWED 16'h84B8

`endif

// >>> rtl/bsi_pkg.sv
`include "bsi_defs.svh"

package bsi_pkg;

    typedef logic [3:0] bsi_line_t;
    typedef logic [`BSI_NUM_LINES-1:0] bsi_mask_t;

    typedef struct packed {
        logic en;
        bsi_line_t line;
    } bsi_route_s;

    typedef bsi_route_s [`BSI_NUM_SRC-1:0] bsi_route_t;

    typedef enum logic [3:0] {
        BSI_SRC_TIMER0,
        BSI_SRC_KEYBOARD,
        BSI_SRC_COM2,
        BSI_SRC_COM1,
        BSI_SRC_FLOPPY,
        BSI_SRC_RTC,
        BSI_SRC_PCI,
        BSI_SRC_MOUSE,
        BSI_SRC_FPU,
        BSI_SRC_DISK,
        BSI_SRC_COM3,
        BSI_SRC_COM4,
        BSI_SRC_LPT,
        BSI_SRC_GP_TIMER,
        BSI_SRC_WATCHDOG
    } bsi_src_e;

    localparam bsi_route_s BSI_DEFAULT_ROUTE [0:`BSI_NUM_SRC-1] = '{
        '{1'b1, `BSI_IRQ_TIMER0},
        '{1'b1, `BSI_IRQ_KEYBOARD},
        '{1'b1, `BSI_IRQ_COM2},
        '{1'b1, `BSI_IRQ_COM1},
        '{1'b1, `BSI_IRQ_FLOPPY},
        '{1'b1, `BSI_IRQ_RTC},
        '{1'b1, `BSI_IRQ_PCI},
        '{1'b1, `BSI_IRQ_MOUSE},
        '{1'b1, `BSI_IRQ_FPU},
        '{1'b1, `BSI_IRQ_DISK},
        '{1'b0, `BSI_IRQ_NONE},
        '{1'b0, `BSI_IRQ_NONE},
        '{1'b0, `BSI_IRQ_NONE},
        '{1'b0, `BSI_IRQ_NONE},
        '{1'b0, `BSI_IRQ_NONE}
    };

    // fixed sources may only sit on their default line
    localparam bsi_mask_t BSI_ALLOWED [0:`BSI_NUM_SRC-1] = '{
        bsi_mask_t'(16'h0001 << `BSI_IRQ_TIMER0),
        bsi_mask_t'(16'h0001 << `BSI_IRQ_KEYBOARD),
        `BSI_GRPA_ALLOWED,
        `BSI_GRPA_ALLOWED,
        bsi_mask_t'(16'h0001 << `BSI_IRQ_FLOPPY),
        bsi_mask_t'(16'h0001 << `BSI_IRQ_RTC),
        `BSI_GRPA_ALLOWED,
        bsi_mask_t'(16'h0001 << `BSI_IRQ_MOUSE),
        bsi_mask_t'(16'h0001 << `BSI_IRQ_FPU),
        bsi_mask_t'(16'h0001 << `BSI_IRQ_DISK),
        `BSI_GRPB_ALLOWED,
        `BSI_GRPB_ALLOWED,
        `BSI_GRPB_ALLOWED,
        `BSI_GRPA_ALLOWED,
        `BSI_GRPA_ALLOWED
    };

endpackage : bsi_pkg

// >>> rtl/bsi_irq_if.sv
`timescale 1ns/1ps
`include "bsi_defs.svh"

interface bsi_irq_if;
    import bsi_pkg::*;

    logic [`BSI_NUM_SRC-1:0] src_req;
    logic cfg_en;
    bsi_route_t route_cfg;
    bsi_mask_t irq_lines;

    modport top (
        output src_req,
        output cfg_en,
        output route_cfg,
        input irq_lines
    );

    modport router (
        input src_req,
        input cfg_en,
        input route_cfg,
        output irq_lines
    );

endinterface : bsi_irq_if

// >>> rtl/bsi_irq_router.sv
`timescale 1ns/1ps
`include "bsi_defs.svh"

module bsi_irq_router
    import bsi_pkg::*;
(
    bsi_irq_if.router bus
);

    bsi_route_s eff [0:`BSI_NUM_SRC-1];
    logic [`BSI_NUM_SRC-1:0] hit;
    logic [`BSI_NUM_SRC-1:0] match [0:`BSI_NUM_LINES-1];
    bsi_mask_t raw;

    for (genvar s = 0; s < `BSI_NUM_SRC; s++)
    begin : g_src
        logic legal;
        // group masks apply
        // an illegal choice falls back to the default route; for sources 10..14 that default is disabled, so the source is dropped
        assign legal = BSI_ALLOWED[s][bus.route_cfg[s].line];
        assign eff[s] = (bus.cfg_en && (legal || !bus.route_cfg[s].en)) ? bus.route_cfg[s]
                                                                          : BSI_DEFAULT_ROUTE[s];
        assign hit[s] = bus.src_req[s] && eff[s].en;
    end

    for (genvar l = 0; l < `BSI_NUM_LINES; l++)
    begin : g_line
        for (genvar s = 0; s < `BSI_NUM_SRC; s++)
        begin : g_cell
            assign match[l][s] = hit[s] && (eff[s].line == bsi_line_t'(l));
        end
        assign raw[l] = |match[l];
    end

    always_comb
    begin
        bus.irq_lines = raw;
        bus.irq_lines[`BSI_CASCADE_LINE] = raw[`BSI_CASCADE_LINE] | (|raw[15:8]);
    end

endmodule : bsi_irq_router

// >>> rtl/bsi_regs.sv
`timescale 1ns/1ps
`include "bsi_defs.svh"

module bsi_regs
    import bsi_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host i/o bus
    input wire logic [15:0] io_addr_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic [7:0] io_wdata_i,
    output logic io_sel_o,
    output logic io_ack_o,
    output logic [7:0] io_rdata_o,
    // board jumpers and straps
    input wire logic firmware_select_jumper_i,
    input wire logic general_input_jumper_i,
    input wire logic ext_temp_strap_i,
    // interrupt routing
    input wire logic [`BSI_NUM_SRC-1:0] irq_src_i,
    input wire logic route_override_i,
    input wire bsi_pkg::bsi_route_t route_cfg_i,
    output logic [`BSI_NUM_LINES-1:0] irq_o
);

    import bsi_pkg::*;

    typedef struct packed {
        logic [7:0] rdata;
        logic ack;
        logic strap_taken;
        logic extended_temperature_flag;
        logic [`BSI_NUM_LINES-1:0] irq;
    } bsi_state_s;

    bsi_state_s state_q;
    bsi_state_s state_d;

    bsi_irq_if irq_bus ();

    logic hit_jumper;
    logic hit_ident;
    logic [7:0] jumper_status;
    logic [7:0] board_identification;
    logic unused_wdata;

    // routing lives in its own module so the register decode stays small
    bsi_irq_router u_router (
        .bus(irq_bus.router)
    );

    assign irq_bus.src_req = irq_src_i;
    assign irq_bus.cfg_en = route_override_i;
    assign irq_bus.route_cfg = route_cfg_i;

    assign hit_jumper = (io_addr_i == `BSI_ADDR_JUMPER);
    assign hit_ident = (io_addr_i == `BSI_ADDR_IDENT);

    // write data has nowhere to go: every bit here is read-only or reserved
    assign unused_wdata = ^io_wdata_i;

    always_comb
    begin
        jumper_status = 8'h00;
        jumper_status[`BSI_FW_SEL_BIT] = firmware_select_jumper_i;
        jumper_status[`BSI_GEN_IN_BIT] = general_input_jumper_i;
    end

    always_comb
    begin
        board_identification = 8'h00;
        board_identification[`BSI_PROD_MSB:`BSI_PROD_LSB] = `BSI_PRODUCT_CODE;
        board_identification[`BSI_REV_MSB:`BSI_REV_LSB] = `BSI_REV_CURRENT;
        board_identification[`BSI_EXT_TEMP_BIT] = state_q.extended_temperature_flag;
    end

    always_comb
    begin
        state_d = state_q;
        state_d.ack = 1'b0;

        // strap is caught on the first edge after reset release, then frozen
        if (!state_q.strap_taken)
        begin
            state_d.strap_taken = 1'b1;
            state_d.extended_temperature_flag = ext_temp_strap_i;
        end

        if (io_rd_i && hit_jumper)
        begin
            state_d.rdata = jumper_status;
            state_d.ack = 1'b1;
        end
        else if (io_rd_i && hit_ident)
        begin
            state_d.rdata = board_identification;
            state_d.ack = 1'b1;
        end
        else if (io_wr_i && (hit_jumper || hit_ident))
        begin
            state_d.ack = 1'b1;
        end

        state_d.irq = irq_bus.irq_lines;
    end

    always_ff @(posedge clk_i or posedge rst_i)
    begin
        if (rst_i)
        begin
            state_q.rdata <= `BSI_RDATA_RESET;
            state_q.ack <= 1'b0;
            state_q.strap_taken <= 1'b0;
            state_q.extended_temperature_flag <= 1'b0;
            state_q.irq <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // other devices share the i/o space, so an unmapped port just gets no select
    assign io_sel_o = hit_jumper || hit_ident;
    assign io_ack_o = state_q.ack;
    assign io_rdata_o = state_q.rdata;
    assign irq_o = state_q.irq;

endmodule : bsi_regs

// >>> testbench/bsi_regs_chk.sv
`timescale 1ns/1ps
`include "bsi_defs.svh"
module bsi_regs_chk
    import bsi_pkg::*;
(
    // clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // host bus
    input wire logic [15:0] io_addr_i,
    input wire logic io_rd_i,
    input wire logic io_wr_i,
    input wire logic io_sel_o,
    input wire logic io_ack_o,
    input wire logic [7:0] io_rdata_o,
    // jumpers and interrupts
    input wire logic firmware_select_jumper_i,
    input wire logic general_input_jumper_i,
    input wire logic [14:0] irq_src_i,
    input wire logic route_override_i,
    input wire logic [15:0] irq_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    property p_sel; io_sel_o == (io_addr_i == 16'h00E0 || io_addr_i == 16'h00E1); endproperty
    a_sel: assert property (p_sel) else $error("select decode wrong");
    property p_ack; (io_rd_i || io_wr_i) && io_sel_o |=> io_ack_o; endproperty
    a_ack: assert property (p_ack) else $error("mapped access not acked");
    property p_jmp; io_rd_i && io_addr_i == 16'h00E0 |=> io_rdata_o ==
        {2'h0, $past(firmware_select_jumper_i), 4'h0, $past(general_input_jumper_i)}; endproperty
    a_jmp: assert property (p_jmp) else $error("jumper byte wrong");
    property p_id; io_rd_i && io_addr_i == 16'h00E1 |=> io_rdata_o[7:1] == {`BSI_PRODUCT_CODE, 2'h0}; endproperty
    a_id: assert property (p_id) else $error("id byte wrong");
    property p_wr; io_wr_i && !io_rd_i |=> $stable(io_rdata_o); endproperty
    a_wr: assert property (p_wr) else $error("write changed read data");
    property p_irq; !route_override_i && irq_src_i[3] |=> irq_o[4]; endproperty
    a_irq: assert property (p_irq) else $error("default line missing");
    property p_idle; !route_override_i |=> (irq_o & 16'h86A0) == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("unused line raised");
    property p_casc; |irq_o[15:8] |-> irq_o[2]; endproperty
    a_casc: assert property (p_casc) else $error("cascade line low");
    c_id: cover property (io_rd_i && io_addr_i == 16'h00E1);
    c_wr: cover property (io_wr_i && io_sel_o);
    c_ovr: cover property (route_override_i && |irq_o);
endmodule : bsi_regs_chk

bind bsi_regs bsi_regs_chk u_chk (.*);

// >>> testbench/board_status_id_regs_test.sv
`timescale 1ns/1ps
`include "bsi_defs.svh"
module board_status_id_regs_test;
    import bsi_pkg::*;
    logic clk_i = 1'b0, rst_i = 1'b1, io_rd_i = 1'b0, io_wr_i = 1'b0, route_override_i = 1'b0;
    logic firmware_select_jumper_i = 1'b0, general_input_jumper_i = 1'b0, ext_temp_strap_i = 1'b1;
    logic [15:0] io_addr_i = 16'h0000;
    logic [7:0] io_wdata_i = 8'h00;
    logic [14:0] irq_src_i = 15'h0000;
    bsi_route_t route_cfg_i = '0;
    logic io_sel_o, io_ack_o;
    logic [7:0] io_rdata_o;
    logic [15:0] irq_o;
    int num_errors = 0, n_tests = 0;
    // default line of sources 0..9; the rest start disabled
    int line_of [10] = '{0, 1, 3, 4, 6, 8, 11, 12, 13, 14};

    always #4 clk_i = ~clk_i;

    bsi_regs uut (.*);

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        n_tests++;
        if (s !== e)
        begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    // one strobe edge; the answer is looked at one cycle later
    task automatic io(input logic wr, input logic [15:0] a, input logic ack, input logic [7:0] e);
        @(negedge clk_i);
        io_addr_i = a;
        io_rd_i = !wr;
        io_wr_i = wr;
        io_wdata_i = 8'hFF;
        #1 chk("sel", 16'(ack), 16'(io_sel_o));
        @(negedge clk_i);
        io_rd_i = 1'b0;
        io_wr_i = 1'b0;
        chk("ack", 16'(ack), 16'(io_ack_o));
        chk("rdata", 16'(e), 16'(io_rdata_o));
    endtask : io

    function automatic logic [15:0] ln(input int l);
        ln = 16'h0001 << l;
        // upper lines also light the cascade
        if (l > 7)
            ln[2] = 1'b1;
    endfunction : ln

    task automatic irq(input int s, input logic ov, input logic [15:0] e);
        @(negedge clk_i);
        irq_src_i = 15'(1 << s);
        route_override_i = ov;
        @(negedge clk_i);
        chk("irq", e, irq_o);
    endtask : irq

    task automatic do_reset(input logic ext_temp);
        ext_temp_strap_i = ext_temp;
        rst_i = 1'b1;
        repeat (20) @(negedge clk_i);
        chk("rst rdata", 16'h0000, 16'(io_rdata_o));
        chk("rst irq", 16'h0000, irq_o);
        rst_i = 1'b0;
        repeat (2) @(negedge clk_i);
    endtask : do_reset

    task automatic stop_test;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : stop_test

    initial
    begin
        #20000;
        num_errors++;
        stop_test();
    end

    initial
    begin
        logic [7:0] id;
        do_reset(1'b1);
        id = {`BSI_PRODUCT_CODE, `BSI_REV_CURRENT, 1'b1};
        io(1'b0, 16'h00E1, 1'b1, id);
        io(1'b1, 16'h00E1, 1'b1, id);
        io(1'b1, 16'h00E0, 1'b1, id);
        io(1'b0, 16'h00E2, 1'b0, id);
        $display("test ident done");
        for (int j = 0; j < 4; j++)
        begin
            firmware_select_jumper_i = j[1];
            general_input_jumper_i = j[0];
            io(1'b0, 16'h00E0, 1'b1, {2'h0, j[1], 4'h0, j[0]});
        end
        $display("test jumper done");
        do_reset(1'b0);
        io(1'b0, 16'h00E1, 1'b1, {`BSI_PRODUCT_CODE, `BSI_REV_CURRENT, 1'b0});
        $display("test strap done");
        for (int s = 0; s < 15; s++)
            irq(s, 1'b0, s < 10 ? ln(line_of[s]) : 16'h0000);
        $display("test default done");
        route_cfg_i[10] = {1'b1, 4'h5};
        route_cfg_i[11] = {1'b1, 4'h9};
        route_cfg_i[13] = {1'b1, 4'h9};
        route_cfg_i[0] = {1'b1, 4'h7};
        irq(10, 1'b1, ln(5));
        irq(11, 1'b1, 16'h0000);
        irq(13, 1'b1, ln(9));
        irq(0, 1'b1, ln(0));
        irq(3, 1'b1, 16'h0000);
        $display("test override done");
        stop_test();
    end
endmodule : board_status_id_regs_test
